// ### rtl/fifo_params.svh
// Constants shared by both ends of the triple-port FIFO link
`ifndef FIFO_PARAMS_SVH
`define FIFO_PARAMS_SVH
`define LW_W 36
`define PIECE_W 18
`define BYTE_W 9
`define ADDR_W 11
`define PTR_W 12
`define FIFO_DEPTH 2048
`define DEPTH_CNT 12'h800
`define AE_OFFSET 12'h008
`define PTR_RST 12'h000
`define BYTE_LAST 2'h3
`define WORD_LAST 2'h1
`define BYTE_STEP 6'h09
`define WORD_STEP 6'h12
`define HOST_CE_DIV 4'h2
`define TX_CE_DIV 4'h3
`define RX_CE_DIV 4'h4
`endif

// ### rtl/fifo_pkg.sv
// Types shared by both ends of the triple-port FIFO link
`default_nettype none
`include "fifo_params.svh"
package fifo_pkg;
   typedef logic [`LW_W-1:0] lword_t;
   typedef logic [`PIECE_W-1:0] piece_t;
   typedef logic [`PTR_W-1:0] ptr_t;
   typedef logic [1:0] idx_t;
endpackage
`default_nettype wire

// ### rtl/fifo_link_if.sv
// Pin bundle between the FIFO device and its port masters
`timescale 1ns/1ps
`default_nettype none
`include "fifo_params.svh"
interface fifo_link_if;
   // Port enables, one per port
   logic host_ce;
   logic tx_ce;
   logic rx_ce;
   // Static configuration
   logic endian_sel;
   logic fall_through_mode;
   logic tx_port_width_sel;
   logic rx_port_width_sel;
   // Port A
   logic host_en;
   logic host_select_n;
   logic host_dir;
   logic host_mailbox_sel;
   logic [`LW_W-1:0] host_wdata;
   logic host_wdata_oe;
   logic [`LW_W-1:0] host_rdata;
   logic host_oe;
   logic host_full_n;
   logic host_in_ready;
   logic host_empty_n;
   logic host_out_valid;
   logic host_almost_empty_n;
   // Port B
   logic tx_rd_en;
   logic tx_select_n;
   logic tx_mailbox_sel;
   logic [`PIECE_W-1:0] tx_rdata;
   logic tx_empty_n;
   logic tx_out_valid;
   logic tx_almost_empty_n;
   // Port C
   logic rx_wr_en;
   logic rx_mailbox_sel;
   logic [`PIECE_W-1:0] rx_wdata;
   logic rx_full_n;
   logic rx_in_ready;

   modport dev (
      input host_ce, tx_ce, rx_ce, endian_sel, fall_through_mode, tx_port_width_sel, rx_port_width_sel,
      input host_en, host_select_n, host_dir, host_mailbox_sel, host_wdata, host_wdata_oe,
      input tx_rd_en, tx_select_n, tx_mailbox_sel, rx_wr_en, rx_mailbox_sel, rx_wdata,
      output host_rdata, host_oe, host_full_n, host_in_ready, host_empty_n, host_out_valid,
      output host_almost_empty_n, tx_rdata, tx_empty_n, tx_out_valid, tx_almost_empty_n,
      output rx_full_n, rx_in_ready
   );
   modport host (
      output host_ce, tx_ce, rx_ce, endian_sel, fall_through_mode, tx_port_width_sel, rx_port_width_sel,
      output host_en, host_select_n, host_dir, host_mailbox_sel, host_wdata, host_wdata_oe,
      output tx_rd_en, tx_select_n, tx_mailbox_sel, rx_wr_en, rx_mailbox_sel, rx_wdata,
      input host_rdata, host_oe, host_full_n, host_in_ready, host_empty_n, host_out_valid,
      input host_almost_empty_n, tx_rdata, tx_empty_n, tx_out_valid, tx_almost_empty_n,
      input rx_full_n, rx_in_ready
   );
endinterface
`default_nettype wire

// ### rtl/fifo_dev_end.sv
// Device end: two long-word FIFOs, port flag timing and port B/C bus matching
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "fifo_params.svh"
module fifo_dev_end (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Pins of the three ports
   fifo_link_if.dev lnk
);

   function automatic fifo_pkg::idx_t last_idx(logic byte_m);
      last_idx = byte_m ? `BYTE_LAST : `WORD_LAST;
   endfunction

   // Piece offset from the top bit
   function automatic logic [5:0] shift_amt(fifo_pkg::idx_t idx, logic byte_m, logic big);
      fifo_pkg::idx_t k;
      k = big ? idx : (last_idx(byte_m) - idx);
      shift_amt = byte_m ? ({4'h0, k} * `BYTE_STEP) : ({4'h0, k} * `WORD_STEP);
   endfunction

   function automatic fifo_pkg::piece_t get_piece(fifo_pkg::lword_t lw, logic [5:0] amt, logic byte_m);
      fifo_pkg::lword_t sh;
      sh = lw << amt;
      get_piece = byte_m ? {{(`PIECE_W-`BYTE_W){1'b0}}, sh[`LW_W-1 -: `BYTE_W]} : sh[`LW_W-1 -: `PIECE_W];
   endfunction

   function automatic fifo_pkg::lword_t put_piece(fifo_pkg::lword_t lw, fifo_pkg::piece_t p, logic [5:0] amt,
                                                  logic byte_m);
      fifo_pkg::lword_t val;
      fifo_pkg::lword_t msk;
      val = byte_m ? ({p[`BYTE_W-1:0], {(`LW_W-`BYTE_W){1'b0}}} >> amt)
                   : ({p, {(`LW_W-`PIECE_W){1'b0}}} >> amt);
      msk = byte_m ? ({{`BYTE_W{1'b1}}, {(`LW_W-`BYTE_W){1'b0}}} >> amt)
                   : ({{`PIECE_W{1'b1}}, {(`LW_W-`PIECE_W){1'b0}}} >> amt);
      put_piece = (lw & ~msk) | val;
   endfunction

   function automatic fifo_pkg::ptr_t fill(fifo_pkg::ptr_t w, fifo_pkg::ptr_t r);
      fill = w - r;
   endfunction

   // Storage
   fifo_pkg::lword_t mem1 [`FIFO_DEPTH];
   fifo_pkg::lword_t mem2 [`FIFO_DEPTH];

   // Static configuration
   logic ft;
   logic big;
   logic byte_b;
   logic byte_c;

   // First FIFO: port A writes, port B reads
   fifo_pkg::ptr_t wptr1_ff;
   fifo_pkg::ptr_t rptr1_ff;
   fifo_pkg::ptr_t nxt_wptr1;
   fifo_pkg::ptr_t nxt_rptr1;
   fifo_pkg::idx_t idx_b_ff;
   fifo_pkg::lword_t lw_b_ff;
   fifo_pkg::lword_t src_b;
   fifo_pkg::piece_t tx_rdata_ff;
   logic [5:0] amt_b;
   logic wr_a;
   logic rd_b;
   logic take_b;
   logic last_b;
   logic tx_flag_ff;
   logic tx_ae_n_ff;
   logic host_room_ff;

   // Second FIFO: port C writes, port A reads
   fifo_pkg::ptr_t wptr2_ff;
   fifo_pkg::ptr_t rptr2_ff;
   fifo_pkg::ptr_t nxt_wptr2;
   fifo_pkg::ptr_t nxt_rptr2;
   fifo_pkg::idx_t idx_c_ff;
   fifo_pkg::lword_t asm_c_ff;
   fifo_pkg::lword_t placed_c;
   fifo_pkg::lword_t host_rdata_ff;
   logic [5:0] amt_c;
   logic wr_c;
   logic commit_c;
   logic rd_a;
   logic take_a;
   logic host_flag_ff;
   logic nxt_host_flag;
   logic host_ae_n_ff;
   logic host_oe_ff;
   logic rx_room_ff;

   assign ft = lnk.fall_through_mode;
   assign big = lnk.endian_sel;
   assign byte_b = lnk.tx_port_width_sel;
   assign byte_c = lnk.rx_port_width_sel;

   // Port A write; refused while full
   always_comb begin
      wr_a = lnk.host_ce && lnk.host_en && !lnk.host_select_n && lnk.host_dir && !lnk.host_mailbox_sel
             && host_room_ff;
      nxt_wptr1 = wptr1_ff + fifo_pkg::ptr_t'(wr_a);
   end

   always_ff @(posedge clk) begin
      if (wr_a) begin
         mem1[wptr1_ff[`ADDR_W-1:0]] <= lnk.host_wdata;
      end
   end

   // Port B unpacking; a word stays counted until its last piece
   always_comb begin
      rd_b = lnk.tx_ce && lnk.tx_rd_en && !lnk.tx_select_n && !lnk.tx_mailbox_sel;
      if (ft) begin
         take_b = lnk.tx_ce && (wptr1_ff != rptr1_ff) && (!tx_flag_ff || rd_b);
      end else begin
         take_b = rd_b && (wptr1_ff != rptr1_ff);
      end
      amt_b = shift_amt(idx_b_ff, byte_b, big);
      src_b = (idx_b_ff == 2'h0) ? mem1[rptr1_ff[`ADDR_W-1:0]] : lw_b_ff;
      last_b = take_b && (idx_b_ff == last_idx(byte_b));
      nxt_rptr1 = last_b ? rptr1_ff + fifo_pkg::ptr_t'(1'b1) : rptr1_ff;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wptr1_ff <= `PTR_RST;
      end else begin
         wptr1_ff <= nxt_wptr1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rptr1_ff <= `PTR_RST;
         idx_b_ff <= 2'h0;
         lw_b_ff <= '0;
         tx_rdata_ff <= '0;
      end else if (take_b) begin
         tx_rdata_ff <= get_piece(src_b, amt_b, byte_b);
         lw_b_ff <= src_b;
         idx_b_ff <= last_b ? 2'h0 : idx_b_ff + 2'h1;
         rptr1_ff <= nxt_rptr1;
      end
   end

   // Flags load only on their own port's enable
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_flag_ff <= 1'b0;
         tx_ae_n_ff <= 1'b0;
      end else if (lnk.tx_ce) begin
         if (ft) begin
            tx_flag_ff <= take_b || (tx_flag_ff && !rd_b);
         end else begin
            tx_flag_ff <= wptr1_ff != nxt_rptr1;
         end
         tx_ae_n_ff <= fill(wptr1_ff, nxt_rptr1) > `AE_OFFSET;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         host_room_ff <= 1'b0;
      end else if (lnk.host_ce) begin
         host_room_ff <= fill(nxt_wptr1, rptr1_ff) != `DEPTH_CNT;
      end
   end

   // Port C packing; whole long words only
   always_comb begin
      wr_c = lnk.rx_ce && lnk.rx_wr_en && !lnk.rx_mailbox_sel && rx_room_ff;
      amt_c = shift_amt(idx_c_ff, byte_c, big);
      placed_c = put_piece(asm_c_ff, lnk.rx_wdata, amt_c, byte_c);
      commit_c = wr_c && (idx_c_ff == last_idx(byte_c));
      nxt_wptr2 = wptr2_ff + fifo_pkg::ptr_t'(commit_c);
   end

   always_ff @(posedge clk) begin
      if (commit_c) begin
         mem2[wptr2_ff[`ADDR_W-1:0]] <= placed_c;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wptr2_ff <= `PTR_RST;
         idx_c_ff <= 2'h0;
         asm_c_ff <= '0;
      end else if (wr_c) begin
         asm_c_ff <= placed_c;
         idx_c_ff <= commit_c ? 2'h0 : idx_c_ff + 2'h1;
         wptr2_ff <= nxt_wptr2;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_room_ff <= 1'b0;
      end else if (lnk.rx_ce) begin
         rx_room_ff <= fill(nxt_wptr2, rptr2_ff) + fifo_pkg::ptr_t'(ft && host_flag_ff)
                       != `DEPTH_CNT;
      end
   end

   // Port A read from the second FIFO
   always_comb begin
      rd_a = lnk.host_ce && lnk.host_en && !lnk.host_select_n && !lnk.host_dir && !lnk.host_mailbox_sel;
      if (ft) begin
         take_a = lnk.host_ce && (wptr2_ff != rptr2_ff) && (!host_flag_ff || rd_a);
      end else begin
         take_a = rd_a && (wptr2_ff != rptr2_ff);
      end
      nxt_rptr2 = rptr2_ff + fifo_pkg::ptr_t'(take_a);
      nxt_host_flag = ft ? (take_a || (host_flag_ff && !rd_a)) : (wptr2_ff != nxt_rptr2);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rptr2_ff <= `PTR_RST;
         host_rdata_ff <= '0;
      end else if (take_a) begin
         host_rdata_ff <= mem2[rptr2_ff[`ADDR_W-1:0]];
         rptr2_ff <= nxt_rptr2;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         host_flag_ff <= 1'b0;
         host_ae_n_ff <= 1'b0;
      end else if (lnk.host_ce) begin
         host_flag_ff <= nxt_host_flag;
         host_ae_n_ff <= fill(wptr2_ff, nxt_rptr2) + fifo_pkg::ptr_t'(ft && nxt_host_flag) > `AE_OFFSET;
      end
   end

   // Port A drive; one cycle behind the pins, a trade for a registered enable
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         host_oe_ff <= 1'b0;
      end else begin
         host_oe_ff <= !lnk.host_select_n && !lnk.host_dir;
      end
   end

   // Paired flags share one flop; the mode picks the meaning
   assign lnk.tx_rdata = tx_rdata_ff;
   assign lnk.tx_empty_n = tx_flag_ff;
   assign lnk.tx_out_valid = tx_flag_ff;
   assign lnk.tx_almost_empty_n = tx_ae_n_ff;
   assign lnk.host_rdata = host_rdata_ff;
   assign lnk.host_oe = host_oe_ff;
   assign lnk.host_empty_n = host_flag_ff;
   assign lnk.host_out_valid = host_flag_ff;
   assign lnk.host_almost_empty_n = host_ae_n_ff;
   assign lnk.host_full_n = host_room_ff;
   assign lnk.host_in_ready = host_room_ff;
   assign lnk.rx_full_n = rx_room_ff;
   assign lnk.rx_in_ready = rx_room_ff;

endmodule
`default_nettype wire

// ### rtl/fifo_host_end.sv
// Master end: drives the three ports of the FIFO device from simple user requests
`timescale 1ns/1ps
`default_nettype none
`include "fifo_params.svh"
module fifo_host_end (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Configuration, taken once after reset
   input wire logic cfg_endian,
   input wire logic cfg_fall_through,
   input wire logic cfg_tx_byte,
   input wire logic cfg_rx_byte,
   // Port A requests
   input wire logic a_wr_req,
   input wire logic a_rd_req,
   input wire logic [`LW_W-1:0] a_wdata,
   output logic a_done,
   output logic [`LW_W-1:0] a_rdata,
   // Port B requests
   input wire logic b_rd_req,
   output logic b_done,
   output logic [`PIECE_W-1:0] b_rdata,
   // Port C requests
   input wire logic c_wr_req,
   input wire logic [`PIECE_W-1:0] c_wdata,
   output logic c_done,
   // Device pins
   fifo_link_if.host lnk
);

   localparam logic [3:0] DIV_LAST [3] = '{`HOST_CE_DIV - 4'h1, `TX_CE_DIV - 4'h1, `RX_CE_DIV - 4'h1};

   logic cfg_done_ff;
   logic endian_ff;
   logic ft_ff;
   logic txb_ff;
   logic rxb_ff;
   logic [3:0] div_ff [3];
   logic [2:0] ce_ff;
   logic a_busy_ff;
   logic a_en_ff;
   logic a_sel_n_ff;
   logic a_dir_ff;
   logic a_oe_ff;
   logic a_cap_ff;
   logic a_done_ff;
   logic [`LW_W-1:0] a_wdata_ff;
   logic [`LW_W-1:0] a_rdata_ff;
   logic b_busy_ff;
   logic b_sel_n_ff;
   logic b_cap_ff;
   logic b_done_ff;
   logic [`PIECE_W-1:0] b_rdata_ff;
   logic c_busy_ff;
   logic c_done_ff;
   logic [`PIECE_W-1:0] c_wdata_ff;

   // Configuration is caught once; the device needs it static
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfg_done_ff <= 1'b0;
         endian_ff <= 1'b0;
         ft_ff <= 1'b0;
         txb_ff <= 1'b0;
         rxb_ff <= 1'b0;
      end else if (!cfg_done_ff) begin
         cfg_done_ff <= 1'b1;
         endian_ff <= cfg_endian;
         ft_ff <= cfg_fall_through;
         txb_ff <= cfg_tx_byte;
         rxb_ff <= cfg_rx_byte;
      end
   end

   // Port rates as one-cycle enables
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 3; i++) begin
            div_ff[i] <= 4'h0;
         end
         ce_ff <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            ce_ff[i] <= div_ff[i] == DIV_LAST[i];
            div_ff[i] <= (div_ff[i] == DIV_LAST[i]) ? 4'h0 : div_ff[i] + 4'h1;
         end
      end
   end

   // Port A: pins held until the device samples them on a port edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         a_busy_ff <= 1'b0;
         a_en_ff <= 1'b0;
         a_sel_n_ff <= 1'b1;
         a_dir_ff <= 1'b0;
         a_oe_ff <= 1'b0;
         a_done_ff <= 1'b0;
         a_wdata_ff <= '0;
      end else if (a_busy_ff) begin
         if (ce_ff[0]) begin
            a_busy_ff <= 1'b0;
            a_en_ff <= 1'b0;
            a_sel_n_ff <= 1'b1;
            a_oe_ff <= 1'b0;
            a_done_ff <= 1'b1;
         end
      end else begin
         a_done_ff <= 1'b0;
         if (cfg_done_ff && (a_wr_req || a_rd_req)) begin
            a_busy_ff <= 1'b1;
            a_en_ff <= 1'b1;
            a_sel_n_ff <= 1'b0;
            a_dir_ff <= a_wr_req;
            a_oe_ff <= a_wr_req;
            a_wdata_ff <= a_wdata;
         end
      end
   end

   // Read data: fall-through shows it before the read edge, standard mode after it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         a_cap_ff <= 1'b0;
         a_rdata_ff <= '0;
         b_cap_ff <= 1'b0;
         b_rdata_ff <= '0;
      end else begin
         a_cap_ff <= a_busy_ff && ce_ff[0] && !a_dir_ff && !ft_ff;
         b_cap_ff <= b_busy_ff && ce_ff[1] && !ft_ff;
         if ((a_busy_ff && ce_ff[0] && !a_dir_ff && ft_ff) || a_cap_ff) begin
            a_rdata_ff <= lnk.host_rdata;
         end
         if ((b_busy_ff && ce_ff[1] && ft_ff) || b_cap_ff) begin
            b_rdata_ff <= lnk.tx_rdata;
         end
      end
   end

   // Port B reads
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         b_busy_ff <= 1'b0;
         b_sel_n_ff <= 1'b1;
         b_done_ff <= 1'b0;
      end else if (b_busy_ff) begin
         if (ce_ff[1]) begin
            b_busy_ff <= 1'b0;
            b_sel_n_ff <= 1'b1;
            b_done_ff <= 1'b1;
         end
      end else begin
         b_done_ff <= 1'b0;
         if (cfg_done_ff && b_rd_req) begin
            b_busy_ff <= 1'b1;
            b_sel_n_ff <= 1'b0;
         end
      end
   end

   // Port C writes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         c_busy_ff <= 1'b0;
         c_done_ff <= 1'b0;
         c_wdata_ff <= '0;
      end else if (c_busy_ff) begin
         if (ce_ff[2]) begin
            c_busy_ff <= 1'b0;
            c_done_ff <= 1'b1;
         end
      end else begin
         c_done_ff <= 1'b0;
         if (cfg_done_ff && c_wr_req) begin
            c_busy_ff <= 1'b1;
            c_wdata_ff <= c_wdata;
         end
      end
   end

   assign lnk.host_ce = ce_ff[0];
   assign lnk.tx_ce = ce_ff[1];
   assign lnk.rx_ce = ce_ff[2];
   assign lnk.endian_sel = endian_ff;
   assign lnk.fall_through_mode = ft_ff;
   assign lnk.tx_port_width_sel = txb_ff;
   assign lnk.rx_port_width_sel = rxb_ff;
   assign lnk.host_en = a_en_ff;
   assign lnk.host_select_n = a_sel_n_ff;
   assign lnk.host_dir = a_dir_ff;
   // Mailboxes unused
   assign lnk.host_mailbox_sel = 1'b0;
   assign lnk.host_wdata = a_wdata_ff;
   assign lnk.host_wdata_oe = a_oe_ff;
   assign lnk.tx_rd_en = b_busy_ff;
   assign lnk.tx_select_n = b_sel_n_ff;
   assign lnk.tx_mailbox_sel = 1'b0;
   assign lnk.rx_wr_en = c_busy_ff;
   assign lnk.rx_mailbox_sel = 1'b0;
   assign lnk.rx_wdata = c_wdata_ff;
   assign a_done = a_done_ff;
   assign a_rdata = a_rdata_ff;
   assign b_done = b_done_ff;
   assign b_rdata = b_rdata_ff;
   assign c_done = c_done_ff;

endmodule
`default_nettype wire

// ### test/fifo_link_sva.sv
// Concurrent checks on the pins between the host end and the device end
`timescale 1ns/1ps
`default_nettype none
`include "fifo_params.svh"
module fifo_link_sva (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Port enables and static setup
   input wire logic host_ce,
   input wire logic tx_ce,
   input wire logic rx_ce,
   input wire logic endian_sel,
   input wire logic fall_through_mode,
   input wire logic tx_port_width_sel,
   input wire logic rx_port_width_sel,
   // Port controls
   input wire logic host_en,
   input wire logic host_select_n,
   input wire logic host_dir,
   input wire logic host_mailbox_sel,
   input wire logic tx_rd_en,
   input wire logic tx_select_n,
   input wire logic tx_mailbox_sel,
   input wire logic rx_wr_en,
   input wire logic rx_mailbox_sel,
   // Device flags
   input wire logic host_full_n,
   input wire logic host_empty_n,
   input wire logic host_out_valid,
   input wire logic host_almost_empty_n,
   input wire logic tx_empty_n,
   input wire logic tx_out_valid,
   input wire logic tx_almost_empty_n,
   input wire logic rx_full_n
);
   logic a_wr_take, a_rd_take, b_take, c_take, b_last, c_last;
   logic [1:0] b_pc_ff, c_pc_ff;
   logic [2:0] run_ff;
   fifo_pkg::ptr_t f1_cnt_ff, f2_cnt_ff;
   assign a_wr_take = host_ce && host_en && !host_select_n && host_dir && !host_mailbox_sel && host_full_n;
   assign a_rd_take = host_ce && host_en && !host_select_n && !host_dir && !host_mailbox_sel && host_empty_n;
   assign b_take = tx_ce && tx_rd_en && !tx_select_n && !tx_mailbox_sel && tx_empty_n;
   assign c_take = rx_ce && rx_wr_en && !rx_mailbox_sel && rx_full_n;
   assign b_last = b_take && b_pc_ff == (tx_port_width_sel ? 2'h3 : 2'h1);
   assign c_last = c_take && c_pc_ff == (rx_port_width_sel ? 2'h3 : 2'h1);
   // Shadow long-word counts
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         b_pc_ff <= 2'h0;
         c_pc_ff <= 2'h0;
         run_ff <= 3'h0;
         f1_cnt_ff <= 12'h000;
         f2_cnt_ff <= 12'h000;
      end else begin
         if (b_take) b_pc_ff <= b_last ? 2'h0 : b_pc_ff + 2'h1;
         if (c_take) c_pc_ff <= c_last ? 2'h0 : c_pc_ff + 2'h1;
         if (run_ff != 3'h7) run_ff <= run_ff + 3'h1;
         f1_cnt_ff <= f1_cnt_ff + fifo_pkg::ptr_t'(a_wr_take) - fifo_pkg::ptr_t'(b_last);
         f2_cnt_ff <= f2_cnt_ff + fifo_pkg::ptr_t'(c_last) - fifo_pkg::ptr_t'(a_rd_take);
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   sequence s_tx_fill;
      a_wr_take && !tx_out_valid;
   endsequence
   sequence s_host_fill;
      c_last && !host_out_valid;
   endsequence
   a_tx_std_rise: assert property (s_tx_fill ##0 !fall_through_mode |-> ##[1:4] tx_empty_n)
      else $error("tx empty late");
   a_tx_ft_load: assert property (s_tx_fill ##0 fall_through_mode |-> ##[1:10] tx_out_valid)
      else $error("tx valid late");
   a_tx_last_drop: assert property (b_last && f1_cnt_ff == 12'h001 && !a_wr_take |=> !tx_empty_n)
      else $error("tx flag kept");
   a_host_std_rise: assert property (s_host_fill ##0 !fall_through_mode |-> ##[1:3] host_empty_n)
      else $error("host empty late");
   a_host_ft_load: assert property (s_host_fill ##0 fall_through_mode |-> ##[1:7] host_out_valid)
      else $error("host valid late");
   a_host_room_back: assert property (b_last && f1_cnt_ff == `DEPTH_CNT |-> ##[1:3] host_full_n)
      else $error("host room late");
   a_rx_fill_drop: assert property (c_last && f2_cnt_ff == `DEPTH_CNT - 12'h001 && !a_rd_take |=> !rx_full_n)
      else $error("rx room kept");
   a_rx_room_back: assert property (a_rd_take && f2_cnt_ff == `DEPTH_CNT |-> ##[1:5] rx_full_n)
      else $error("rx room late");
   a_tx_ae_rise: assert property (a_wr_take && f1_cnt_ff == `AE_OFFSET && !b_last |-> ##[1:4] tx_almost_empty_n)
      else $error("tx almost-empty late");
   a_host_ae_rise: assert property (c_last && f2_cnt_ff == `AE_OFFSET && !a_rd_take |-> ##[1:3] host_almost_empty_n)
      else $error("host almost-empty late");
   a_tx_own_edge: assert property ($changed(tx_empty_n) || $changed(tx_almost_empty_n) |-> $past(tx_ce))
      else $error("tx flag off edge");
   a_host_own_edge: assert property ($changed(host_full_n) || $changed(host_empty_n) |-> $past(host_ce))
      else $error("host flag off edge");
   a_cfg_fixed: assert property (run_ff == 3'h7 |-> $stable(endian_sel) && $stable(tx_port_width_sel))
      else $error("config moved");
endmodule
`default_nettype wire

// ### test/dual_fifo_flag_sync_byte_read_tb.sv
// Self-checking bench: host end and device end joined over the link interface
`timescale 1ns/1ps
`default_nettype none
`include "fifo_params.svh"
module dual_fifo_flag_sync_byte_read_tb;
   logic clk, rstn, cfg_endian, cfg_fall_through, cfg_tx_byte, cfg_rx_byte;
   logic a_wr_req, a_rd_req, b_rd_req, c_wr_req, a_done, b_done, c_done;
   fifo_pkg::lword_t a_wdata, a_rdata;
   fifo_pkg::piece_t b_rdata, c_wdata;
   int err_count, samples_checked;
   fifo_link_if lnk();
   fifo_host_end i_fifo_host_end (.clk(clk), .rstn(rstn), .cfg_endian(cfg_endian), .cfg_fall_through(cfg_fall_through),
      .cfg_tx_byte(cfg_tx_byte), .cfg_rx_byte(cfg_rx_byte), .a_wr_req(a_wr_req), .a_rd_req(a_rd_req),
      .a_wdata(a_wdata), .a_done(a_done), .a_rdata(a_rdata), .b_rd_req(b_rd_req), .b_done(b_done),
      .b_rdata(b_rdata), .c_wr_req(c_wr_req), .c_wdata(c_wdata), .c_done(c_done), .lnk(lnk.host));
   fifo_dev_end i_fifo_dev_end (.clk(clk), .rstn(rstn), .lnk(lnk.dev));
   fifo_link_sva i_fifo_link_sva (.clk(clk), .rstn(rstn), .host_ce(lnk.host_ce), .tx_ce(lnk.tx_ce), .rx_ce(lnk.rx_ce),
      .endian_sel(lnk.endian_sel), .fall_through_mode(lnk.fall_through_mode),
      .tx_port_width_sel(lnk.tx_port_width_sel), .rx_port_width_sel(lnk.rx_port_width_sel),
      .host_en(lnk.host_en), .host_select_n(lnk.host_select_n), .host_dir(lnk.host_dir),
      .host_mailbox_sel(lnk.host_mailbox_sel), .tx_rd_en(lnk.tx_rd_en), .tx_select_n(lnk.tx_select_n),
      .tx_mailbox_sel(lnk.tx_mailbox_sel), .rx_wr_en(lnk.rx_wr_en), .rx_mailbox_sel(lnk.rx_mailbox_sel),
      .host_full_n(lnk.host_full_n), .host_empty_n(lnk.host_empty_n), .host_out_valid(lnk.host_out_valid),
      .host_almost_empty_n(lnk.host_almost_empty_n), .tx_empty_n(lnk.tx_empty_n), .tx_out_valid(lnk.tx_out_valid),
      .tx_almost_empty_n(lnk.tx_almost_empty_n), .rx_full_n(lnk.rx_full_n));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   function automatic fifo_pkg::lword_t pat(input int k);
      return 36'h9A5C3E1F0 ^ {k[11:0], k[11:0], k[11:0]};
   endfunction
   // Piece i of a long word in transfer order
   function automatic fifo_pkg::lword_t piece(input fifo_pkg::lword_t w, input int i, input logic byt);
      int k;
      k = cfg_endian ? (byt ? 3 - i : 1 - i) : i;
      return byt ? {27'h0, w[k*9 +: 9]} : {18'h0, w[k*18 +: 18]};
   endfunction
   function automatic logic flag(input int w);
      return w == 0 ? lnk.host_full_n : w == 1 ? lnk.host_empty_n : w == 2 ? lnk.tx_empty_n : lnk.rx_full_n;
   endfunction
   task automatic chk_data(input fifo_pkg::lword_t got, input fifo_pkg::lword_t exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: data %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: flag %b, expected %b", $time, got, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // One transfer: 0 port A write, 1 port A read, 2 port B read, 3 port C write
   task automatic go(input int w, input fifo_pkg::lword_t d, output fifo_pkg::lword_t r);
      int n;
      n = 0;
      while (flag(w) !== 1'b1 && n < 200) begin
         settle(1);
         n++;
      end
      @(posedge clk);
      a_wr_req <= (w == 0);
      a_rd_req <= (w == 1);
      b_rd_req <= (w == 2);
      c_wr_req <= (w == 3);
      a_wdata <= d;
      c_wdata <= d[17:0];
      @(posedge clk);
      {a_wr_req, a_rd_req, b_rd_req, c_wr_req} <= 4'h0;
      n = 0;
      do begin
         settle(1);
         n++;
      end while ((w == 2 ? b_done : w == 3 ? c_done : a_done) !== 1'b1 && n < 100);
      chk_flag(n < 100, 1'b1);
      // Standard read data stands one cycle after done
      if (!cfg_fall_through && (w == 1 || w == 2)) settle(1);
      r = (w == 1) ? a_rdata : {18'h0, b_rdata};
   endtask
   task automatic run_cfg(input logic [3:0] c, input int t);
      fifo_pkg::lword_t r;
      int np, nq;
      @(posedge clk);
      rstn <= 1'b0;
      {cfg_endian, cfg_fall_through, cfg_tx_byte, cfg_rx_byte} <= c;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      settle(1);
      np = cfg_tx_byte ? 4 : 2;
      nq = cfg_rx_byte ? 4 : 2;
      for (int k = 0; k < 9; k++) begin
         go(0, pat(k), r);
         if (k > 6) settle(4);
         if (k > 6) chk_flag(lnk.tx_almost_empty_n, k == 8);
      end
      for (int k = 0; k < 9 * np; k++) begin
         go(2, 36'h0, r);
         chk_data(cfg_tx_byte ? {27'h0, r[8:0]} : r, piece(pat(k / np), k % np, cfg_tx_byte));
      end
      chk_flag(lnk.tx_empty_n, 1'b0);
      for (int k = 0; k < 9 * nq; k++) begin
         go(3, piece(pat(k / nq + 16), k % nq, cfg_rx_byte), r);
         if (k % nq == nq - 1 && k / nq > 6) settle(3);
         if (k % nq == nq - 1 && k / nq > 6) chk_flag(lnk.host_almost_empty_n, k / nq == 8);
      end
      for (int k = 0; k < 9; k++) begin
         go(1, 36'h0, r);
         chk_data(r, pat(k + 16));
      end
      if (t % 2 == 0) begin
         for (int k = 0; k < `FIFO_DEPTH; k++) go(0, pat(k), r);
         chk_flag(lnk.host_full_n, 1'b0);
         for (int k = 0; k < np; k++) go(2, 36'h0, r);
         settle(4);
         chk_flag(lnk.host_full_n, 1'b1);
      end
      if (t == 1) begin
         for (int k = 0; k < `FIFO_DEPTH * nq; k++) go(3, piece(pat(k / nq), k % nq, cfg_rx_byte), r);
         chk_flag(lnk.rx_in_ready, 1'b0);
         go(1, 36'h0, r);
         chk_data(r, pat(0));
         settle(5);
         chk_flag(lnk.rx_in_ready, 1'b1);
      end
      $display("test %0d done", t);
   endtask
   task automatic conclude();
      $display("checks %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Run is near 34k cycles
   initial begin
      #500us;
      err_count++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      conclude();
   end
   initial begin
      rstn = 1'b0;
      {cfg_endian, cfg_fall_through, cfg_tx_byte, cfg_rx_byte} = 4'h0;
      {a_wr_req, a_rd_req, b_rd_req, c_wr_req} = 4'h0;
      a_wdata = 36'h0;
      c_wdata = 18'h0;
      err_count = 0;
      samples_checked = 0;
      run_cfg(4'hB, 0);
      run_cfg(4'h4, 1);
      run_cfg(4'hE, 2);
      run_cfg(4'h1, 3);
      conclude();
   end
endmodule
`default_nettype wire
